// [ccrs_regs.vh]
// Purpose: constants for core and memory clock ratio select
// Assumes: config word bits numbered 0 = msb, as the field positions show
// Notes:   registers sit at byte offsets chosen for this block
`ifndef CCRS_REGS_VH
`define CCRS_REGS_VH
`define CCRS_CFG_WIDTH     256
`define CCRS_NUM_CORES     4
// big-endian bit n lives at vector index (CFG_WIDTH-1-n)
`define CCRS_MEM_RATIO_MSB 10
`define CCRS_MEM_RANGE_MSB 8
`define CCRS_MEM_SYNC_BIT  184
`define CCRS_MEM_RATE_BIT  232
`define CCRS_MEM_RSV_BIT   234
// source codes: bit 2 picks pll two, bits 1:0 the divider minus one
`define CCRS_SEL_P1_DIV1   4'h0
`define CCRS_SEL_P1_DIV2   4'h1
`define CCRS_SEL_P2_DIV1   4'h4
`define CCRS_SEL_P2_DIV2   4'h5
`define CCRS_OFF_CORE_SEL  12'h000
`define CCRS_OFF_MEM_CFG   12'h004
`define CCRS_OFF_STATUS    12'h008
`define CCRS_OFF_CFG_LOAD  12'h00C
`define CCRS_RESP_OKAY     2'h0
`define CCRS_RESP_SLVERR   2'h2
`endif

// [ccrs_core_decode.v]
// Purpose: decode one core complex select code into pll source and divider
// Assumes: codes come from a register loaded only during reset
// Notes:   reserved codes fall back to pll one divide by one
`timescale 1ns/100ps
`include "ccrs_regs.vh"
module ccrs_core_decode
#(
    parameter UPPER_SET = 0
)
(
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire [3:0] selCode,
    output reg        usePllTwo,
    output reg        divByTwo,
    output reg        codeValid
);
    reg next_usePllTwo;
    reg next_divByTwo;
    reg next_codeValid;

    always @*
    begin
        next_usePllTwo = 1'b0;
        next_divByTwo  = 1'b0;
        next_codeValid = 1'b1;
        case (selCode)
            `CCRS_SEL_P1_DIV1 : next_codeValid = 1'b1; // [R2] [R3]
            `CCRS_SEL_P2_DIV1 : next_usePllTwo = 1'b1; // [R2] [R3]
            `CCRS_SEL_P1_DIV2 :
            begin
                next_divByTwo  = (UPPER_SET == 0); // [R2]
                next_codeValid = (UPPER_SET == 0);
            end
            `CCRS_SEL_P2_DIV2 :
            begin
                next_usePllTwo = (UPPER_SET != 0); // [R3]
                next_divByTwo  = (UPPER_SET != 0);
                next_codeValid = (UPPER_SET != 0);
            end
            // reserved: flag it, keep a safe clock [R4]
            default : next_codeValid = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usePllTwo <= 1'b0;
            divByTwo  <= 1'b0;
            codeValid <= 1'b0;
        end
        else
        begin
            usePllTwo <= next_usePllTwo;
            divByTwo  <= next_divByTwo;
            codeValid <= next_codeValid;
        end
    end
endmodule

// [ccrs_clock_select.v]
// What this block does
// R1 - each core complex gets its own clock choice from its own 4-bit code.
// R2 - complexes 0,1: 0000 pll one /1, 0001 pll one /2, 0100 pll two /1.
// R3 - complexes 2,3: 0000 pll one /1, 0100 pll two /1, 0101 pll two /2.
// R4 - the source writes only listed codes; others have no defined ratio.
// R5 - memory pll may run async, referenced to the system clock input.
// R6 - async memory ratio comes from the 5-bit field at bits 10 to 14.
// R7 - the source sets range bits 8 to 9 to 01 above cutoff, else 00.
// R8 - the source clears the memory sync bit 184 for async mode.
// R9 - the source clears the memory rate bit 232 for async mode.
// R10 - the source always clears reserved memory bit 234.
// R11 - fields are caught while reset is held and kept until next reset.
//
// Purpose: latch the reset config word and drive core and memory clock picks
// Assumes: cfgWord is static while cfgLoad is high; axi4-lite register port
// Notes:   cfgLoad is the device's reset-phase strobe, synchronised here
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ccrs_regs.vh"
module ccrs_clock_select
#(
    parameter NCORE = `CCRS_NUM_CORES,
    parameter CFGW  = `CCRS_CFG_WIDTH
)
(
    input  wire               ref_clk,
    input  wire               rst_n,
    input  wire [CFGW-1:0]    cfgWord,
    input  wire               cfgLoad,
    input  wire [NCORE*4-1:0] coreSelCode,
    output wire [NCORE-1:0]   coreUsePllTwo,
    output wire [NCORE-1:0]   coreDivByTwo,
    output reg                memAsync,
    output reg  [4:0]         memRatio,
    output reg  [1:0]         memRange,
    output wire               cfgError,
    input  wire [11:0]        s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [11:0]        s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready
);
    // big-endian bit number to vector index
    function integer bitIdx;
        input integer n;
        begin
            bitIdx = CFGW - 1 - n;
        end
    endfunction

    reg                loadMeta;
    reg                loadSync;
    reg                loadDone;
    reg [NCORE*4-1:0]  selHeld;
    reg                memSyncBit;
    reg                memRateBit;
    reg                memRsvBit;
    reg [NCORE*4-1:0]  swSel;
    wire [NCORE-1:0]   coreValid;

    // two flops: load strobe comes from the reset sequencer domain
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loadMeta <= 1'b0;
            loadSync <= 1'b0;
        end
        else
        begin
            loadMeta <= cfgLoad;
            loadSync <= loadMeta;
        end
    end

    // capture once per reset; later strobes are ignored [R11]
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loadDone   <= 1'b0;
            selHeld    <= {NCORE*4{1'b0}};
            memAsync   <= 1'b0;
            memRatio   <= 5'h00;
            memRange   <= 2'h0;
            memSyncBit <= 1'b0;
            memRateBit <= 1'b0;
            memRsvBit  <= 1'b0;
        end
        else if (loadSync && !loadDone)
        begin
            loadDone   <= 1'b1; // [R11]
            selHeld    <= coreSelCode; // [R1]
            memSyncBit <= cfgWord[bitIdx(`CCRS_MEM_SYNC_BIT)];
            memRateBit <= cfgWord[bitIdx(`CCRS_MEM_RATE_BIT)];
            memRsvBit  <= cfgWord[bitIdx(`CCRS_MEM_RSV_BIT)];
            // sync bit low means memory pll runs off system clock [R5]
            memAsync   <= ~cfgWord[bitIdx(`CCRS_MEM_SYNC_BIT)]; // [R5] [R8]
            memRatio   <= cfgWord[bitIdx(`CCRS_MEM_RATIO_MSB) -: 5]; // [R6]
            memRange   <= cfgWord[bitIdx(`CCRS_MEM_RANGE_MSB) -: 2]; // [R7]
        end
    end

    // each complex decodes alone; upper half uses the second ratio set
    genvar g;
    generate
        for (g = 0; g < NCORE; g = g + 1)
        begin : gCore
            ccrs_core_decode
            #(
                .UPPER_SET (g >= 2)
            )
            uDec
            (
                .ref_clk   (ref_clk),
                .rst_n     (rst_n),
                .selCode   (selHeld[g*4 +: 4]), // [R1]
                .usePllTwo (coreUsePllTwo[g]),
                .divByTwo  (coreDivByTwo[g]),
                .codeValid (coreValid[g])
            );
        end
    endgenerate

    // source slips are flagged, not corrected [R4] [R9] [R10]
    wire rangeBad = memRange[1];
    wire memBad   = (memAsync & memRateBit) | memRsvBit | rangeBad;
    assign cfgError = loadDone & ((~&coreValid) | memBad);

    // axi4-lite: single outstanding write and read
    reg  awHeld;
    reg  wHeld;
    reg  [11:0] awAddr;
    reg  [31:0] wData;
    // strobe travels with its data word, not with the response
    reg         wStrb0;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 12'h000;
            wData        <= 32'h00000000;
            wStrb0       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CCRS_RESP_OKAY;
            swSel        <= {NCORE*4{1'b0}};
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb0 <= s_axi_wstrb[0];
            end
            if (awHeld && wHeld)
            begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `CCRS_RESP_OKAY;
                // scratch copy only: live selections never move [R11]
                if (awAddr == `CCRS_OFF_CORE_SEL && wStrb0)
                    swSel <= wData[NCORE*4-1:0];
                else if (awAddr != `CCRS_OFF_CORE_SEL)
                    s_axi_bresp <= `CCRS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `CCRS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `CCRS_RESP_OKAY;
            case (s_axi_araddr)
                `CCRS_OFF_CORE_SEL : s_axi_rdata <= {16'h0000, selHeld};
                `CCRS_OFF_MEM_CFG  : s_axi_rdata <= {21'h000000, memRsvBit,
                    memRateBit, memSyncBit, memAsync, memRange, memRatio};
                `CCRS_OFF_STATUS   : s_axi_rdata <= {24'h000000, coreValid,
                    coreUsePllTwo[1:0], cfgError, loadDone};
                `CCRS_OFF_CFG_LOAD : s_axi_rdata <= {16'h0000, swSel};
                default :
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `CCRS_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
endmodule

// [ccrs_props.sv]
// Purpose: assertions on clock picks and register read answers
// Assumes: cfgWord and codes held still around the first load pulse
// Notes:   memory fields settle three edges after the load edge, picks four
`timescale 1ns/100ps
module ccrs_props
(
    input wire         ref_clk,
    input wire         rst_n,
    input wire [255:0] cfgWord,
    input wire         cfgLoad,
    input wire [15:0]  coreSelCode,
    input wire [3:0]   coreUsePllTwo,
    input wire [3:0]   coreDivByTwo,
    input wire         memAsync,
    input wire [4:0]   memRatio,
    input wire [1:0]   memRange,
    input wire         s_axi_arvalid,
    input wire         s_axi_arready,
    input wire         s_axi_rvalid,
    input wire         s_axi_rready
);
    logic       seen;
    logic [2:0] age;
    // only the first pulse after reset counts, later ones are ignored
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
        begin
            seen <= 1'b0;
            age  <= 3'h0;
        end
        else
        begin
            seen <= seen | cfgLoad;
            if (seen && age != 3'h7)
                age <= age + 3'h1;
        end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ratio_capture: assert property (
        cfgLoad && !seen |-> ##3 memRatio == $past(cfgWord[245:241], 3))
        else $error("memory ratio differs from its field");
    a_range_capture: assert property (
        cfgLoad && !seen |-> ##3 memRange == $past(cfgWord[247:246], 3))
        else $error("memory range differs from its field");
    a_async_mode: assert property (
        cfgLoad && !seen |-> ##3 memAsync == !$past(cfgWord[71], 3))
        else $error("async mode differs from sync bit");
    a_low_select: assert property (
        cfgLoad && !seen |-> ##4
        coreUsePllTwo[1] == ($past(coreSelCode[7:4], 4) == 4'h4) &&
        coreDivByTwo[1] == ($past(coreSelCode[7:4], 4) == 4'h1))
        else $error("complex one pick is wrong");
    a_high_select: assert property (
        cfgLoad && !seen |-> ##4
        coreUsePllTwo[3] == ($past(coreSelCode[15:12], 4) inside {4'h4, 4'h5})
        && coreDivByTwo[3] == ($past(coreSelCode[15:12], 4) == 4'h5))
        else $error("complex three pick is wrong");
    a_pick_hold: assert property (
        age == 3'h7 && $past(age) == 3'h7 |-> $stable({coreUsePllTwo,
        coreDivByTwo, memAsync, memRatio, memRange}))
        else $error("clock picks moved after load");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer stayed after handshake");
endmodule
bind ccrs_clock_select ccrs_props u_props
(
    .ref_clk(ref_clk), .rst_n(rst_n), .cfgWord(cfgWord),
    .cfgLoad(cfgLoad), .coreSelCode(coreSelCode),
    .coreUsePllTwo(coreUsePllTwo), .coreDivByTwo(coreDivByTwo),
    .memAsync(memAsync), .memRatio(memRatio), .memRange(memRange),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// [tb_top.sv]
// Purpose: self-checking bench for the clock ratio select block
// Assumes: one reset and one load pulse per case
// Notes:   bus handshakes sampled at the falling edge, held until taken
`timescale 1ns/100ps
`include "ccrs_regs.vh"
module tb_top;
    typedef struct packed {
        logic [15:0] c;
        logic [4:0]  r;
        logic [1:0]  g;
        logic [3:0]  p;
        logic [3:0]  d;
    } ccrs_row_t;
    ccrs_row_t rows [3] = '{'{16'h4010, 5'h00, 2'h0, 4'h8, 4'h2},
        '{16'h0504, 5'h1F, 2'h1, 4'h5, 4'h4},
        '{16'h5441, 5'h0A, 2'h0, 4'hE, 4'h9}};
    logic         ref_clk = 1'b0, rst_n = 1'b0, cfgLoad = 1'b0;
    logic [255:0] cfgWord = '0;
    logic [15:0]  coreSelCode = 16'h0000;
    logic [3:0]   coreUsePllTwo, coreDivByTwo;
    logic         memAsync, cfgError, awr, wr, arr, bv, rv;
    logic [4:0]   memRatio;
    logic [1:0]   memRange, bresp, rresp, rsp;
    logic [11:0]  aw = 12'h000, ar = 12'h000;
    logic [31:0]  wd = 32'h0, rd, dat;
    logic         awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    int           failures = 0, comparisons = 0;
    ccrs_clock_select dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .cfgWord(cfgWord),
        .cfgLoad(cfgLoad), .coreSelCode(coreSelCode),
        .coreUsePllTwo(coreUsePllTwo), .coreDivByTwo(coreDivByTwo),
        .memAsync(memAsync), .memRatio(memRatio), .memRange(memRange),
        .cfgError(cfgError), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
    );
    always #50 ref_clk = ~ref_clk;
    function automatic logic [255:0] mk(input logic [4:0] r,
        input logic [1:0] g, input logic s, input logic t, input logic v);
        mk = '0;
        mk[245:241] = r;
        mk[247:246] = g;
        mk[71] = s;
        mk[23] = t;
        mk[21] = v;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic load(input logic [15:0] c, input logic [255:0] w);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        coreSelCode <= c;
        cfgWord <= w;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        cfgLoad <= 1'b1;
        @(posedge ref_clk);
        cfgLoad <= 1'b0;
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge ref_clk);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (1)
        begin
            @(negedge ref_clk);
            ta = awv && awr;
            tw = wv && wr;
            tb = bv;
            rsp = bresp;
            @(posedge ref_clk);
            if (ta)
                awv <= 1'b0;
            if (tw)
                wv <= 1'b0;
            if (tb)
            begin
                br <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axr(input logic [11:0] a);
        logic ta, tb;
        @(posedge ref_clk);
        ar <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (1)
        begin
            @(negedge ref_clk);
            ta = arv && arr;
            tb = rv;
            dat = rd;
            rsp = rresp;
            @(posedge ref_clk);
            if (ta)
                arv <= 1'b0;
            if (tb)
            begin
                rr <= 1'b0;
                break;
            end
        end
    endtask
    task automatic close_out();
        $display("counts: %0d compared, %0d failed", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // the whole run is just over a hundred cycles, so this margin is generous
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        failures++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check({coreUsePllTwo, coreDivByTwo, memAsync, cfgError}, 0);
        foreach (rows[i])
        begin
            load(rows[i].c, mk(rows[i].r, rows[i].g, 1'b0, 1'b0, 1'b0));
            check(coreUsePllTwo, rows[i].p);
            check(coreDivByTwo, rows[i].d);
            check({memAsync, memRange, memRatio},
                {1'b1, rows[i].g, rows[i].r});
            check(cfgError, 0);
            $display("row %0d done", i);
        end
        // a late pulse with new inputs must not move anything
        @(posedge ref_clk);
        coreSelCode <= 16'h0000;
        cfgWord <= mk(5'h15, 2'h1, 1'b1, 1'b0, 1'b0);
        cfgLoad <= 1'b1;
        @(posedge ref_clk);
        cfgLoad <= 1'b0;
        repeat (5) @(negedge ref_clk);
        check({coreUsePllTwo, coreDivByTwo}, 8'hE9);
        check({memAsync, memRatio}, {1'b1, 5'h0A});
        load(16'h0105, mk(5'h03, 2'h0, 1'b1, 1'b1, 1'b0));
        check({coreUsePllTwo, coreDivByTwo}, 8'h00);
        check({cfgError, memAsync}, 2'b10);
        for (int k = 0; k < 3; k++)
        begin
            load(16'h0000, mk(5'h00, k == 0 ? 2'h2 : 2'h0, 1'b0,
                k == 1, k == 2));
            check(cfgError, 1);
        end
        $display("reserved cases done");
        axw(`CCRS_OFF_CORE_SEL, 32'hA5A55A5A);
        check(rsp, `CCRS_RESP_OKAY);
        check({coreUsePllTwo, coreDivByTwo}, 8'h00);
        // scratch keeps one 4-bit code per complex, upper half reads zero
        axr(`CCRS_OFF_CFG_LOAD);
        check(dat, 32'h00005A5A);
        axr(12'h010);
        check(dat, 0);
        check(rsp, `CCRS_RESP_SLVERR);
        axw(12'h010, 32'h1);
        check(rsp, `CCRS_RESP_SLVERR);
        axr(`CCRS_OFF_STATUS);
        check(dat[0], 1);
        // last load: reserved bit set, sync bit clear, range and ratio zero
        axr(`CCRS_OFF_MEM_CFG);
        check(dat, 32'h00000480);
        check(rsp, `CCRS_RESP_OKAY);
        $display("bus cases done");
        close_out();
    end
endmodule
